// ==== rtl/pwr_pkg.sv ====
// Behaviour
// - idle entered after writing instruction completes
// - idle keeps state, peripherals stay clocked
// - enabled interrupt or reset pin ends idle
// - interrupt wake clears idle, resumes cpu
// - reset ending idle restarts at vector
// - watchdog overflow during idle forces reset
// - software disables watchdog for endless idle
// - software follows idle write with multibyte instruction
// - stop entered after writing instruction completes
// - stop silences all but missing clock detector
// - only reset exits stop, restarts at vector
// - software disables detector before long stop
// - software powers down analog before stop
// - power control at 0x87, resets zero
// - stop and idle bits read zero
// - priority register a bit layout
// - priority register b layout, resets zero
// - global enable gates every individual mask
package pwr_pkg;
	localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] EXT_IRQ_PRIORITY_A_ADDR = 8'hF6;
	localparam logic [7:0] EXT_IRQ_PRIORITY_B_ADDR = 8'hF7;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] EXT_IRQ_PRIORITY_A_RESET = 8'h00;
	localparam logic [7:0] EXT_IRQ_PRIORITY_B_RESET = 8'h00;
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam logic [7:0] PRIO_MASK = 8'h7F;
	localparam int CMP2_PRIO_BIT = 6;
	localparam int CMP1_PRIO_BIT = 5;
	localparam int CMP0_PRIO_BIT = 4;
	localparam int COUNTER_ARRAY_PRIO_BIT = 3;
	localparam int ADC0_WINDOW_PRIO_BIT = 2;
	localparam int SMBUS_PRIO_BIT = 1;
	localparam int SPI_PRIO_BIT = 0;
	localparam int UART1_PRIO_BIT = 6;
	localparam int CAN_PRIO_BIT = 5;
	localparam int ADC2_EOC_PRIO_BIT = 4;
	localparam int ADC2_WINDOW_PRIO_BIT = 3;
	localparam int TIMER4_PRIO_BIT = 2;
	localparam int ADC0_EOC_PRIO_BIT = 1;
	localparam int TIMER3_PRIO_BIT = 0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam int NUM_SRC = 14;
	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_PEND = 2'b01,
		PM_IDLE = 2'b11,
		PM_STOP = 2'b10
	} pmode_e;
endpackage

// ==== rtl/pwr_if.sv ====
`timescale 1ns/1ps
interface pwr_if (
	input wire logic mclk,
	input wire logic rst_n
);
	logic [7:0] sfrAddr;
	logic [7:0] sfrWdata;
	logic sfrWr;
	logic sfrRd;
	logic [7:0] sfrRdata;
	logic instrDone;
	logic [13:0] irqReq;
	logic [13:0] irqMask;
	logic globalIrqEnable;
	logic resetPinN;
	logic watchdogOverflow;
	logic clockMissing;
	logic cpuClkEn;
	logic oscRun;
	logic periphClkEn;
	logic wakeIrq;
	logic coreReset;
	logic [15:0] fetchVector;
	logic [13:0] irqHighPrio;
	modport device (
		input sfrAddr, sfrWdata, sfrWr, sfrRd, instrDone, irqReq, irqMask,
		input globalIrqEnable, resetPinN, watchdogOverflow, clockMissing,
		output sfrRdata, cpuClkEn, oscRun, periphClkEn, wakeIrq, coreReset,
		output fetchVector, irqHighPrio
	);
	modport core (
		output sfrAddr, sfrWdata, sfrWr, sfrRd, instrDone, irqReq, irqMask,
		output globalIrqEnable, resetPinN, watchdogOverflow, clockMissing,
		input sfrRdata, cpuClkEn, oscRun, periphClkEn, wakeIrq, coreReset,
		input fetchVector, irqHighPrio
	);
endinterface

// ==== rtl/power_mode_ctrl.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module power_mode_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link to core
	pwr_if.device bus
);
	pwr_pkg::pmode_e mode_q;
	logic [7:0] prioA_q;
	logic [7:0] prioB_q;
	logic [7:0] rdata_q;
	logic idleReq_q;
	logic stopReq_q;
	logic rpin1_q, rpin2_q, rpin3_q;
	logic pinLow_q;
	logic pinReset;
	logic anyEnabled;
	logic intReset;
	logic wrPcon;
	logic wrPrioA;
	logic wrPrioB;
	logic askStop;
	logic askIdle;
	logic powerReq;
	logic inRun;
	logic inPend;
	logic inIdle;
	logic inStop;
	// named priority fields, register a
	logic cmp2Prio;
	logic cmp1Prio;
	logic cmp0Prio;
	logic counterArrayPrio;
	logic adc0WindowPrio;
	logic smbusPrio;
	logic spiPrio;
	// named priority fields, register b
	logic uart1Prio;
	logic canPrio;
	logic adc2EocPrio;
	logic adc2WindowPrio;
	logic timer4Prio;
	logic adc0EocPrio;
	logic timer3Prio;

	// reset pin sync, three stages
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rpin1_q <= 1'b1;
			rpin2_q <= 1'b1;
			rpin3_q <= 1'b1;
		end else begin
			rpin1_q <= bus.resetPinN;
			rpin2_q <= rpin1_q;
			rpin3_q <= rpin2_q;
		end
	end

	// pin level counts only once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinLow_q <= 1'b0;
		end else if (rpin2_q == rpin3_q) begin
			pinLow_q <= !rpin3_q;
		end
	end
	assign pinReset = pinLow_q;

	// mode decode
	assign inRun = mode_q == pwr_pkg::PM_RUN;
	assign inPend = mode_q == pwr_pkg::PM_PEND;
	assign inIdle = mode_q == pwr_pkg::PM_IDLE;
	assign inStop = mode_q == pwr_pkg::PM_STOP;

	// internal resets; in stop only the detector lives
	assign intReset = (bus.watchdogOverflow && !inStop)
		|| bus.clockMissing;
	assign anyEnabled = bus.globalIrqEnable && |(bus.irqReq & bus.irqMask);

	// register write decode
	assign wrPcon = bus.sfrWr && bus.sfrAddr == pwr_pkg::POWER_CONTROL_ADDR;
	assign wrPrioA = bus.sfrWr && bus.sfrAddr == pwr_pkg::EXT_IRQ_PRIORITY_A_ADDR;
	assign wrPrioB = bus.sfrWr && bus.sfrAddr == pwr_pkg::EXT_IRQ_PRIORITY_B_ADDR;

	// a written one asks for a mode, a written zero does nothing
	assign askStop = wrPcon && bus.sfrWdata[pwr_pkg::STOP_BIT];
	assign askIdle = wrPcon && bus.sfrWdata[pwr_pkg::IDLE_BIT];
	assign powerReq = askStop || askIdle;

	// requested mode, held until a reset; an interrupt wake clears the idle request
	always_ff @(posedge mclk) begin
		if (!rst_n || pinReset || intReset) begin
			idleReq_q <= 1'b0;
			stopReq_q <= 1'b0;
		end else if (inRun && powerReq) begin
			stopReq_q <= askStop;
			idleReq_q <= askIdle;
		end else if (inIdle && anyEnabled) begin
			idleReq_q <= 1'b0;
		end
	end

	// power mode sequencing
	always_ff @(posedge mclk) begin
		if (!rst_n || pinReset || intReset) begin
			mode_q <= pwr_pkg::PM_RUN;
		end else begin
			unique case (mode_q)
				pwr_pkg::PM_RUN: begin
					if (powerReq) begin
						mode_q <= pwr_pkg::PM_PEND;
					end
				end
				pwr_pkg::PM_PEND: begin
					if (bus.instrDone) begin
						if (stopReq_q) begin
							mode_q <= pwr_pkg::PM_STOP;
						end else if (idleReq_q) begin
							mode_q <= pwr_pkg::PM_IDLE;
						end else begin
							mode_q <= pwr_pkg::PM_RUN;
						end
					end
				end
				pwr_pkg::PM_IDLE: begin
					if (anyEnabled) begin
						mode_q <= pwr_pkg::PM_RUN;
					end
				end
				pwr_pkg::PM_STOP: begin
					mode_q <= pwr_pkg::PM_STOP;
				end
			endcase
		end
	end

	// priority register a, bit 7 stays zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prioA_q <= pwr_pkg::EXT_IRQ_PRIORITY_A_RESET;
		end else if (wrPrioA) begin
			prioA_q <= bus.sfrWdata & pwr_pkg::PRIO_MASK;
		end
	end

	// priority register b, bit 7 stays zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prioB_q <= pwr_pkg::EXT_IRQ_PRIORITY_B_RESET;
		end else if (wrPrioB) begin
			prioB_q <= bus.sfrWdata & pwr_pkg::PRIO_MASK;
		end
	end

	// field view of register a
	assign cmp2Prio = prioA_q[pwr_pkg::CMP2_PRIO_BIT];
	assign cmp1Prio = prioA_q[pwr_pkg::CMP1_PRIO_BIT];
	assign cmp0Prio = prioA_q[pwr_pkg::CMP0_PRIO_BIT];
	assign counterArrayPrio = prioA_q[pwr_pkg::COUNTER_ARRAY_PRIO_BIT];
	assign adc0WindowPrio = prioA_q[pwr_pkg::ADC0_WINDOW_PRIO_BIT];
	assign smbusPrio = prioA_q[pwr_pkg::SMBUS_PRIO_BIT];
	assign spiPrio = prioA_q[pwr_pkg::SPI_PRIO_BIT];

	// field view of register b; a one always means high
	assign uart1Prio = prioB_q[pwr_pkg::UART1_PRIO_BIT];
	assign canPrio = prioB_q[pwr_pkg::CAN_PRIO_BIT];
	assign adc2EocPrio = prioB_q[pwr_pkg::ADC2_EOC_PRIO_BIT];
	assign adc2WindowPrio = prioB_q[pwr_pkg::ADC2_WINDOW_PRIO_BIT];
	assign timer4Prio = prioB_q[pwr_pkg::TIMER4_PRIO_BIT];
	assign adc0EocPrio = prioB_q[pwr_pkg::ADC0_EOC_PRIO_BIT];
	assign timer3Prio = prioB_q[pwr_pkg::TIMER3_PRIO_BIT];

	// read data one cycle after strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= pwr_pkg::READ_ZERO;
		end else if (bus.sfrRd) begin
			unique case (bus.sfrAddr)
				pwr_pkg::POWER_CONTROL_ADDR: rdata_q <= pwr_pkg::READ_ZERO;
				pwr_pkg::EXT_IRQ_PRIORITY_A_ADDR: rdata_q <= prioA_q;
				pwr_pkg::EXT_IRQ_PRIORITY_B_ADDR: rdata_q <= prioB_q;
				default: rdata_q <= pwr_pkg::READ_ZERO;
			endcase
		end else begin
			rdata_q <= pwr_pkg::READ_ZERO;
		end
	end

	// clock controls to core
	assign bus.cpuClkEn = inRun || inPend;
	assign bus.periphClkEn = !inStop;
	assign bus.oscRun = !inStop;
	// wake, reset and read data to core
	assign bus.wakeIrq = inIdle && anyEnabled;
	assign bus.coreReset = pinReset || intReset;
	assign bus.fetchVector = pwr_pkg::RESET_VECTOR;
	assign bus.sfrRdata = rdata_q;

	// priority levels out, register b above register a
	assign bus.irqHighPrio = {
		uart1Prio,
		canPrio,
		adc2EocPrio,
		adc2WindowPrio,
		timer4Prio,
		adc0EocPrio,
		timer3Prio,
		cmp2Prio,
		cmp1Prio,
		cmp0Prio,
		counterArrayPrio,
		adc0WindowPrio,
		smbusPrio,
		spiPrio
	};
endmodule

// ==== rtl/core_side.sv ====
`timescale 1ns/1ps
module core_side (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// user command port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// core status inputs
	input wire logic instrDone,
	input wire logic [13:0] irqReq,
	input wire logic [13:0] irqMask,
	input wire logic globalIrqEnable,
	input wire logic resetPinN,
	input wire logic watchdogOverflow,
	input wire logic clockMissing,
	// observed controls
	output logic cpuRunning,
	output logic resetSeen,
	// link
	pwr_if.core bus
);
	logic resetSeen_q;

	// forward orders; software keeps rules 7, 8, 12, 13
	assign bus.sfrAddr = addr;
	assign bus.sfrWdata = wdata;
	assign bus.sfrWr = wr;
	assign bus.sfrRd = rd;
	assign bus.instrDone = instrDone;
	assign bus.irqReq = irqReq;
	assign bus.irqMask = irqMask;
	assign bus.globalIrqEnable = globalIrqEnable;
	assign bus.resetPinN = resetPinN;
	assign bus.watchdogOverflow = watchdogOverflow;
	assign bus.clockMissing = clockMissing;
	assign rdata = bus.sfrRdata;
	assign cpuRunning = bus.cpuClkEn;

	// sticky reset observation
	always_ff @(posedge mclk) begin
		if (!rst_n)
			resetSeen_q <= 1'b0;
		else if (bus.coreReset)
			resetSeen_q <= 1'b1;
	end
	assign resetSeen = resetSeen_q;
endmodule

// ==== bench/pwr_properties.sv ====
`timescale 1ns/1ps
module pwr_properties (
	// watched link signals
	input wire logic mclk, rst_n, instrDone, globalIrqEnable, resetPinN,
	input wire logic cpuClkEn, oscRun, periphClkEn, wakeIrq, coreReset,
	input wire logic [13:0] irqReq, irqMask,
	input wire logic [15:0] fetchVector
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic pend;
	// an enabled request is waiting
	assign pend = globalIrqEnable && (irqReq & irqMask) != 14'h0000;
	a_halt_after_done: assert property ($fell(cpuClkEn) |-> $past(instrDone))
		else $error("halt before done");
	a_idle_periph_on: assert property (oscRun |-> periphClkEn)
		else $error("periph clock off");
	a_stop_all_off: assert property (!oscRun |-> !periphClkEn && !cpuClkEn)
		else $error("clock on in stop");
	a_wake_on_irq: assert property (pend && oscRun && !cpuClkEn |-> wakeIrq ##1 cpuClkEn)
		else $error("no wake");
	a_masked_no_wake: assert property (!globalIrqEnable |-> !wakeIrq)
		else $error("wake while masked");
	a_stop_no_wake: assert property (!oscRun |-> !wakeIrq)
		else $error("irq woke stop");
	a_reset_vector: assert property (coreReset |-> fetchVector == 16'h0000)
		else $error("bad vector");
	a_pin_resets: assert property ($fell(resetPinN) |-> ##[1:4] coreReset)
		else $error("pin reset lost");
endmodule

// ==== bench/core_power_mode_and_irq_priority_bench.sv ====
`timescale 1ns/1ps
module core_power_mode_and_irq_priority_bench;
	logic mclk, rst_n, wr, rd, instrDone, gie, pinN, wdog, missing_clock_detector, run, seen;
	logic [7:0] addr, wdata, rdata;
	logic [13:0] req, msk;
	int n_fail = 0;
	int check_count = 0;
	pwr_if i_pwr_if (.mclk(mclk), .rst_n(rst_n));
	power_mode_ctrl i_power_mode_ctrl (.mclk(mclk), .rst_n(rst_n), .bus(i_pwr_if));
	core_side i_core_side (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .instrDone(instrDone), .irqReq(req), .irqMask(msk),
		.globalIrqEnable(gie), .resetPinN(pinN), .watchdogOverflow(wdog),
		.clockMissing(missing_clock_detector), .cpuRunning(run), .resetSeen(seen), .bus(i_pwr_if));
	pwr_properties i_pwr_properties (.mclk(mclk), .rst_n(rst_n),
		.instrDone(i_pwr_if.instrDone), .globalIrqEnable(i_pwr_if.globalIrqEnable),
		.resetPinN(i_pwr_if.resetPinN), .cpuClkEn(i_pwr_if.cpuClkEn),
		.oscRun(i_pwr_if.oscRun), .periphClkEn(i_pwr_if.periphClkEn),
		.wakeIrq(i_pwr_if.wakeIrq), .coreReset(i_pwr_if.coreReset),
		.irqReq(i_pwr_if.irqReq), .irqMask(i_pwr_if.irqMask),
		.fetchVector(i_pwr_if.fetchVector));
	// compare and count
	task automatic chk(input logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// one-cycle write, then a gap
	task automatic wr8(input logic [7:0] a, d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	// data stands the cycle after the strobe
	task automatic rchk(input logic [7:0] a, e);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic t_regs();
		rchk(8'h87, 8'h00);
		rchk(8'hF6, 8'h00);
		rchk(8'hF7, 8'h00);
		wr8(8'hF6, 8'hFF);
		wr8(8'hF7, 8'hA5);
		rchk(8'hF6, 8'h7F);
		rchk(8'hF7, 8'h25);
		rchk(8'h10, 8'h00);
		chk(i_pwr_if.irqHighPrio, 14'h12FF);
	endtask
	// idle waits for the write to finish, wakes on enabled irq only
	task automatic t_idle();
		wr8(8'h87, 8'h01);
		cyc(3);
		chk(run, 1'b1);
		instrDone <= 1'b1;
		cyc(2);
		chk(run, 1'b0);
		rchk(8'hF6, 8'h7F);
		req <= 14'h0001;
		msk <= 14'h0001;
		cyc(3);
		chk(run, 1'b0);
		gie <= 1'b1;
		cyc(2);
		chk(run, 1'b1);
		rchk(8'h87, 8'h00);
	endtask
	// stop ignores irq and watchdog, leaves here through the reset pin
	task automatic t_stop();
		gie <= 1'b0;
		wr8(8'h87, 8'h02);
		cyc(3);
		chk(i_pwr_if.oscRun, 1'b0);
		gie <= 1'b1;
		wdog <= 1'b1;
		cyc(3);
		chk(run, 1'b0);
		chk(seen, 1'b0);
		wdog <= 1'b0;
		pinN <= 1'b0;
		cyc(6);
		pinN <= 1'b1;
		cyc(5);
		chk(run, 1'b1);
		chk(i_pwr_if.coreReset, 1'b0);
		chk(seen, 1'b1);
		gie <= 1'b0;
	endtask
	task automatic t_wdt();
		wr8(8'h87, 8'h01);
		cyc(3);
		chk(run, 1'b0);
		wdog <= 1'b1;
		cyc(4);
		chk(run, 1'b1);
		wdog <= 1'b0;
		wr8(8'h87, 8'h02);
		cyc(2);
		chk(i_pwr_if.oscRun, 1'b0);
		missing_clock_detector <= 1'b1;
		cyc(2);
		chk(run, 1'b1);
		missing_clock_detector <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		{rst_n, wr, rd, instrDone, gie, wdog, missing_clock_detector, addr, wdata, req, msk} = '0;
		pinN = 1'b1;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_idle();
		t_stop();
		t_wdt();
		final_report();
	end
	initial begin
		#20000;
		n_fail++;
		final_report();
	end
endmodule
